// ### hw/pwm_cascade_led_driver.sv
// Six-channel PWM with two single-wire LED strip transmitters and a Wishbone slave
`timescale 1ns/10ps
`include "pwm_cascade_led_driver_defines.svh"
module pwm_cascade_led_driver (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [17:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic      [5:0]  pwm_o,
    output logic             irq_o
);
    localparam logic [95:0] PER_LO  = `IDX_PER_LO;
    localparam logic [95:0] PER_HI  = `IDX_PER_HI;
    localparam logic [95:0] DUTY_LO = `IDX_DUTY_LO;
    localparam logic [95:0] DUTY_HI = `IDX_DUTY_HI;

    // Merges one written byte into a 16-bit register
    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    // Register storage
    logic [15:0]                            period_q [6];
    logic [15:0]                            duty_q   [6];
    pwm_cascade_led_driver_pkg::ch_ctrl_t   ctrl_q   [6];
    logic [5:0]                             enable_q;
    logic [5:0]                             mask_q;
    logic [5:0]                             flags_q;
    logic [7:0]                             psc_q;
    logic [15:0]                            one_high_q;
    logic [15:0]                            pause_q;
    logic [7:0]                             sdata_q  [2];

    // Bus slave
    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_d;
    wire  [15:0] idx      = adr_i[17:2];
    wire         req      = cyc_i & stb_i;
    wire         wr       = req & we_i & ack_q & sel_i[0];
    wire  [7:0]  wbyte    = dat_i[7:0];

    // Operating clock divider
    logic [7:0]  div_q;
    wire         tick     = (div_q == psc_q);

    // Channel datapath
    logic [15:0] cnt_q    [6];
    logic [5:0]  clkout_q;
    logic [5:0]  pwm_q;
    logic        irq_q;
    logic [5:0]  strip;
    logic [5:0]  run;
    logic [5:0]  wrap;
    logic [5:0]  load;
    logic [5:0]  level;
    logic [15:0] thr      [6];
    logic [5:0]  flag_clr;

    // Strip transmitters, index 0 drives channel 1, index 1 drives channel 2
    pwm_cascade_led_driver_pkg::strip_state_t st_q [2];
    logic [7:0]  shift_q  [2];
    logic [2:0]  bit_q    [2];
    logic [2:0]  bcnt_q   [2];
    logic [15:0] pcnt_q   [2];
    logic [1:0]  full_q;
    logic [1:0]  dat_wr;
    logic [1:0]  byte_done;
    logic [1:0]  busy;

    assign dat_wr[0] = wr & (idx == `IDX_DAT0);
    assign dat_wr[1] = wr & (idx == `IDX_DAT1);
    assign flag_clr  = (wr && idx == `IDX_FLAGS) ? wbyte[5:0] : 6'h00;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            strip[i] = (i == 1 || i == 2) && (ctrl_q[i].burst_byte_count != 3'h0);
            run[i]   = enable_q[i] && (!strip[i] || st_q[(i == 2) ? 1 : 0] == 
                       pwm_cascade_led_driver_pkg::STRIP_SEND);
            wrap[i]  = tick && run[i] && (cnt_q[i] >= period_q[i]);
            load[i]  = 1'b0;
            thr[i]   = duty_q[i];
        end
        for (int s = 0; s < 2; s++) begin
            load[s + 1] = strip[s + 1] && enable_q[s + 1] && full_q[s] &&
                          st_q[s] == pwm_cascade_led_driver_pkg::STRIP_IDLE;
            if (strip[s + 1] && shift_q[s][7]) begin
                thr[s + 1] = one_high_q;
            end
            byte_done[s] = wrap[s + 1] && (bit_q[s] == 3'h7);
            busy[s]      = full_q[s] || st_q[s] == pwm_cascade_led_driver_pkg::STRIP_SEND;
        end
        for (int i = 0; i < 6; i++) begin
            if (period_q[i] == `RST_WORD && !strip[i]) begin
                level[i] = clkout_q[i];
            end else begin
                level[i] = run[i] && (thr[i] != `RST_WORD) && (cnt_q[i] <= thr[i]);
            end
        end
    end

    // Read multiplexer
    always_comb begin
        rd_d = 32'h0000_0000;
        for (int i = 0; i < 6; i++) begin
            if (idx == PER_LO[16*i +: 16])  rd_d[7:0] = period_q[i][7:0];
            if (idx == PER_HI[16*i +: 16])  rd_d[7:0] = period_q[i][15:8];
            if (idx == DUTY_LO[16*i +: 16]) rd_d[7:0] = duty_q[i][7:0];
            if (idx == DUTY_HI[16*i +: 16]) rd_d[7:0] = duty_q[i][15:8];
            if (idx == `IDX_CTRL0 + 16'(i)) rd_d[7:0] = {1'b0, ctrl_q[i], 2'h0};
        end
        case (idx)
            `IDX_ENABLE:   rd_d[5:0] = enable_q;
            `IDX_PSC:      rd_d[7:0] = psc_q;
            `IDX_MASK:     rd_d[5:0] = mask_q;
            `IDX_FLAGS:    rd_d[5:0] = flags_q;
            `IDX_STATUS: begin
                rd_d[`BUSY0_BIT] = busy[0];
                rd_d[`FULL0_BIT] = full_q[0];
                rd_d[`BUSY1_BIT] = busy[1];
                rd_d[`FULL1_BIT] = full_q[1];
            end
            `IDX_DAT0:     rd_d[7:0] = sdata_q[0];
            `IDX_DAT1:     rd_d[7:0] = sdata_q[1];
            `IDX_PAUSE_LO: rd_d[7:0] = pause_q[7:0];
            `IDX_PAUSE_HI: rd_d[7:0] = pause_q[15:8];
            `IDX_ONE_LO:   rd_d[7:0] = one_high_q[7:0];
            `IDX_ONE_HI:   rd_d[7:0] = one_high_q[15:8];
            default:       rd_d = rd_d;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                dat_q <= rd_d;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 6; i++) begin
                period_q[i] <= `RST_WORD;
                duty_q[i]   <= `RST_WORD;
                ctrl_q[i]   <= '0;
            end
            enable_q   <= 6'h00;
            mask_q     <= 6'h00;
            psc_q      <= `RST_BYTE;
            one_high_q <= `RST_WORD;
            pause_q    <= `RST_WORD;
            sdata_q[0] <= `RST_BYTE;
            sdata_q[1] <= `RST_BYTE;
        end else if (wr) begin
            for (int i = 0; i < 6; i++) begin
                if (idx == PER_LO[16*i +: 16])  period_q[i] <= put_byte(period_q[i], 1'b0, wbyte);
                if (idx == PER_HI[16*i +: 16])  period_q[i] <= put_byte(period_q[i], 1'b1, wbyte);
                if (idx == DUTY_LO[16*i +: 16]) duty_q[i] <= put_byte(duty_q[i], 1'b0, wbyte);
                if (idx == DUTY_HI[16*i +: 16]) duty_q[i] <= put_byte(duty_q[i], 1'b1, wbyte);
                if (idx == `IDX_CTRL0 + 16'(i)) ctrl_q[i] <= wbyte[6:2];
            end
            if (idx == `IDX_ENABLE)   enable_q   <= wbyte[5:0];
            if (idx == `IDX_MASK)     mask_q     <= wbyte[5:0];
            if (idx == `IDX_PSC)      psc_q      <= wbyte;
            if (idx == `IDX_PAUSE_LO) pause_q    <= put_byte(pause_q, 1'b0, wbyte);
            if (idx == `IDX_PAUSE_HI) pause_q    <= put_byte(pause_q, 1'b1, wbyte);
            if (idx == `IDX_ONE_LO)   one_high_q <= put_byte(one_high_q, 1'b0, wbyte);
            if (idx == `IDX_ONE_HI)   one_high_q <= put_byte(one_high_q, 1'b1, wbyte);
            if (dat_wr[0])            sdata_q[0] <= wbyte;
            if (dat_wr[1])            sdata_q[1] <= wbyte;
        end
    end

    // Divider, counters, flags and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q    <= `RST_BYTE;
            flags_q  <= 6'h00;
            clkout_q <= 6'h00;
            pwm_q    <= 6'h00;
            irq_q    <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                cnt_q[i] <= `RST_WORD;
            end
        end else begin
            div_q   <= tick ? `RST_BYTE : div_q + 8'h01;
            flags_q <= (flags_q & ~flag_clr) | wrap;
            irq_q   <= |(flags_q & mask_q);
            for (int i = 0; i < 6; i++) begin
                // Idle count rests at one so the first bit also spans one period
                if (load[i] || !run[i]) begin
                    cnt_q[i] <= 16'h0001;
                end else if (tick) begin
                    cnt_q[i] <= wrap[i] ? 16'h0001 : cnt_q[i] + 16'h0001;
                end
                if (tick && enable_q[i]) begin
                    clkout_q[i] <= ~clkout_q[i];
                end
                pwm_q[i] <= enable_q[i] & (level[i] ^ ctrl_q[i].output_invert);
            end
        end
    end

    // Strip transmitters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_q <= 2'h0;
            for (int s = 0; s < 2; s++) begin
                st_q[s]    <= pwm_cascade_led_driver_pkg::STRIP_IDLE;
                shift_q[s] <= `RST_BYTE;
                bit_q[s]   <= 3'h0;
                bcnt_q[s]  <= 3'h0;
                pcnt_q[s]  <= `RST_WORD;
            end
        end else begin
            for (int s = 0; s < 2; s++) begin
                full_q[s] <= dat_wr[s] | (full_q[s] & ~load[s + 1]);
                if (!strip[s + 1]) begin
                    st_q[s]   <= pwm_cascade_led_driver_pkg::STRIP_IDLE;
                    bcnt_q[s] <= 3'h0;
                end else begin
                    case (st_q[s])
                        pwm_cascade_led_driver_pkg::STRIP_IDLE: begin
                            if (load[s + 1]) begin
                                shift_q[s] <= ctrl_q[s + 1].strip_data_invert ?
                                              ~sdata_q[s] : sdata_q[s];
                                bit_q[s]   <= 3'h0;
                                st_q[s]    <= pwm_cascade_led_driver_pkg::STRIP_SEND;
                            end
                        end
                        pwm_cascade_led_driver_pkg::STRIP_SEND: begin
                            if (byte_done[s]) begin
                                if (bcnt_q[s] + 3'h1 == ctrl_q[s + 1].burst_byte_count) begin
                                    bcnt_q[s] <= 3'h0;
                                    pcnt_q[s] <= pause_q;
                                    st_q[s]   <= pwm_cascade_led_driver_pkg::STRIP_PAUSE;
                                end else begin
                                    bcnt_q[s] <= bcnt_q[s] + 3'h1;
                                    st_q[s]   <= pwm_cascade_led_driver_pkg::STRIP_IDLE;
                                end
                            end else if (wrap[s + 1]) begin
                                shift_q[s] <= {shift_q[s][6:0], 1'b0};
                                bit_q[s]   <= bit_q[s] + 3'h1;
                            end
                        end
                        pwm_cascade_led_driver_pkg::STRIP_PAUSE: begin
                            if (tick) begin
                                if (pcnt_q[s] == `RST_WORD) begin
                                    st_q[s] <= pwm_cascade_led_driver_pkg::STRIP_IDLE;
                                end else begin
                                    pcnt_q[s] <= pcnt_q[s] - 16'h0001;
                                end
                            end
                        end
                        default: st_q[s] <= pwm_cascade_led_driver_pkg::STRIP_IDLE;
                    endcase
                end
            end
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign pwm_o = pwm_q;
    assign irq_o = irq_q;

    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|wrap) |=> ((flags_q & $past(wrap)) == $past(wrap)))
        else $error("event did not set its flag");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flag_clr[0] && !wrap[0]) |=> !flags_q[0])
        else $error("flag not cleared by write of one");

    irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (irq_o == |($past(flags_q) & $past(mask_q))))
        else $error("interrupt does not follow masked flags");

    pwm_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_q[0] && period_q[0] != 16'h0000 && duty_q[0] != 16'h0000)
        |=> (pwm_o[0] == (($past(cnt_q[0]) <= $past(duty_q[0])) ^ $past(ctrl_q[0].output_invert))))
        else $error("channel level wrong against threshold");

    load_invert_a: assert property (@(posedge clk_i) disable iff (rst_i)
        load[1] |=> (shift_q[0] == ($past(sdata_q[0]) ^ {8{$past(ctrl_q[1].strip_data_invert)}})))
        else $error("strip byte not loaded with inversion");

    bit_thr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (strip[2] && shift_q[1][7]) |-> (thr[2] == one_high_q))
        else $error("one bit not using shared high time");

    pause_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q[0] == pwm_cascade_led_driver_pkg::STRIP_SEND && byte_done[0] &&
         bcnt_q[0] + 3'h1 == ctrl_q[1].burst_byte_count)
        |=> (st_q[0] == pwm_cascade_led_driver_pkg::STRIP_PAUSE && pcnt_q[0] == $past(pause_q)))
        else $error("pause not started with programmed length");

    busy_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_q && idx == `IDX_STATUS) |=> (dat_o[6] == $past(busy[1]) &&
         dat_o[2] == $past(busy[0])))
        else $error("busy flags read back wrong");

    full_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dat_wr[0] |=> full_q[0])
        else $error("data write did not mark buffer full");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule

// ### include/pwm_cascade_led_driver_defines.svh
// Register indices, field positions and reset values of the PWM and LED strip block
// Behaviour
// - Each channel holds a 16-bit period.
// - Each channel holds a 16-bit high-time threshold.
// - Per-channel event flags in bits 0-5, W1C.
// - Strip bytes shift out MSB first.
// - Data byte 0 feeds channel 1, 1 feeds 2.
// - Bit lasts one period; one/zero pick high time.
// - Inversion applies before sending and picks high time.
// - One shared one-bit high-time register.
// - Pause length plus one ticks after each group.
// - One shared pause length register.
// - Busy flags at bits 6 and 2.
// - High at or below threshold; inversion swaps.
// - Event at period end; interrupt only when enabled.
// - Burst count zero disables strip mode, 1-7 enable.
// - Data write starts sending; buffer reloads; full flag.
`ifndef PWM_CASCADE_LED_DRIVER_DEFINES_SVH
`define PWM_CASCADE_LED_DRIVER_DEFINES_SVH

`define IDX_ENABLE      16'h0090
`define IDX_PSC         16'h00b0
`define IDX_MASK        16'h00b8
`define IDX_CTRL0       16'h00b9
`define IDX_FLAGS       16'h00b7
`define IDX_STATUS      16'h00bf
`define IDX_DAT0        16'h00d7
`define IDX_DAT1        16'h00c7
`define IDX_PAUSE_LO    16'h00ce
`define IDX_PAUSE_HI    16'h00cf
`define IDX_ONE_LO      16'h8060
`define IDX_ONE_HI      16'h8061
`define IDX_PER_LO      {16'h00a7, 16'h00a5, 16'h00af, 16'h00ad, 16'h00ab, 16'h00a9}
`define IDX_PER_HI      {16'h009a, 16'h00a6, 16'h00a4, 16'h00ae, 16'h00ac, 16'h00aa}
`define IDX_DUTY_LO     {16'h0096, 16'h0094, 16'h0092, 16'h009f, 16'h009d, 16'h009b}
`define IDX_DUTY_HI     {16'h0097, 16'h0095, 16'h0093, 16'h0091, 16'h009e, 16'h009c}

`define CTRL_TOG_BIT    6
`define CTRL_MOD_LSB    3
`define CTRL_POL_BIT    2
`define BUSY0_BIT       2
`define FULL0_BIT       3
`define BUSY1_BIT       6
`define FULL1_BIT       7

`define RST_BYTE        8'h00
`define RST_WORD        16'h0000

`endif

// ### include/pwm_cascade_led_driver_pkg.sv
// Types shared by the PWM and LED strip block
package pwm_cascade_led_driver_pkg;

    typedef struct packed {
        logic       output_invert;
        logic [2:0] burst_byte_count;
        logic       strip_data_invert;
    } ch_ctrl_t;

    typedef enum logic [1:0] {
        STRIP_IDLE,
        STRIP_SEND,
        STRIP_PAUSE
    } strip_state_t;

endpackage

// ### testbench/strip_receiver.sv
// Behavioural cascaded LED chip that decodes the single-wire strip into bytes
`timescale 1ns/10ps
module strip_receiver #(
    parameter int THR = 3
) (
    input  wire logic        clk_i,
    input  wire logic        line_i,
    output logic      [15:0] word_o,
    output logic      [7:0]  count_o,
    output logic      [15:0] gap_o
);
    logic       prev;
    logic [7:0] sh;
    int         high;
    int         low;
    int         gap;
    int         nbits;

    initial begin
        prev = 1'b0;
        sh = 8'h00;
        high = 0;
        low = 0;
        gap = 0;
        nbits = 0;
        word_o = 16'h0000;
        count_o = 8'h00;
        gap_o = 16'h0000;
    end

    always @(posedge clk_i) begin
        if (line_i && !prev) begin
            if (nbits == 0) begin
                gap = low;
            end
            high = 0;
        end
        if (!line_i && prev) begin
            // Long high time is a one; bits arrive most significant first
            sh = {sh[6:0], high > THR};
            nbits++;
            low = 0;
            if (nbits == 8) begin
                nbits = 0;
                word_o <= {word_o[7:0], sh};
                count_o <= count_o + 8'h01;
                gap_o <= gap[15:0];
            end
        end
        if (line_i) begin
            high++;
        end else begin
            low++;
        end
        prev = line_i;
    end
endmodule

// ### testbench/test_pwm_cascade_led_driver.sv
// Self-checking bench for the PWM and LED strip block
`timescale 1ns/10ps
`include "pwm_cascade_led_driver_defines.svh"
module test_pwm_cascade_led_driver;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [17:0] adr_i = 18'h00000;
    logic [3:0]  sel_i = 4'h1;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [5:0]  pwm_o;
    logic        irq_o;
    logic [15:0] word1, word2, gap1, gap2;
    logic [7:0]  cnt1, cnt2;
    logic [95:0] per_lo = `IDX_PER_LO;
    logic [95:0] per_hi = `IDX_PER_HI;
    logic [95:0] dut_lo = `IDX_DUTY_LO;
    logic [95:0] dut_hi = `IDX_DUTY_HI;
    int          num_errors = 0;
    int          n_tests = 0;

    always #2.5 clk_i = ~clk_i;

    pwm_cascade_led_driver pwm_cascade_led_driver_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o), .irq_o(irq_o));
    strip_receiver strip_receiver_i (.clk_i(clk_i), .line_i(pwm_o[1]), .word_o(word1),
        .count_o(cnt1), .gap_o(gap1));
    strip_receiver strip_receiver_2_i (.clk_i(clk_i), .line_i(pwm_o[2]), .word_o(word2),
        .count_o(cnt2), .gap_o(gap2));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h000000, wd};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, idx, d, r);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        wb(1'b0, idx, 8'h00, r);
        chk({24'h0, r}, {24'h0, exp});
    endtask

    task automatic reset_values;
        rd_chk(`IDX_FLAGS, 8'h00);
        rd_chk(`IDX_STATUS, 8'h00);
        rd_chk(per_hi[80 +: 16], 8'h00);
        rd_chk(`IDX_DAT0, 8'h00);
        rd_chk(`IDX_ONE_HI, 8'h00);
        rd_chk(16'h0001, 8'h00);
    endtask

    task automatic reg_access;
        for (int c = 0; c < 6; c++) begin
            wr(per_lo[16*c +: 16], 8'h10 + c[7:0]);
            wr(per_hi[16*c +: 16], 8'h20 + c[7:0]);
            wr(dut_lo[16*c +: 16], 8'h30 + c[7:0]);
            wr(dut_hi[16*c +: 16], 8'h40 + c[7:0]);
        end
        for (int c = 0; c < 6; c++) begin
            rd_chk(per_lo[16*c +: 16], 8'h10 + c[7:0]);
            rd_chk(per_hi[16*c +: 16], 8'h20 + c[7:0]);
            rd_chk(dut_lo[16*c +: 16], 8'h30 + c[7:0]);
            rd_chk(dut_hi[16*c +: 16], 8'h40 + c[7:0]);
            wr(per_hi[16*c +: 16], 8'h00);
            wr(dut_hi[16*c +: 16], 8'h00);
        end
        wr(`IDX_PAUSE_HI, 8'h5a);
        rd_chk(`IDX_PAUSE_HI, 8'h5a);
        wr(`IDX_PAUSE_HI, 8'h00);
        wr(`IDX_ONE_HI, 8'ha5);
        rd_chk(`IDX_ONE_HI, 8'ha5);
        wr(`IDX_ONE_HI, 8'h00);
        wr(`IDX_STATUS, 8'hff);
        rd_chk(`IDX_STATUS, 8'h00);
        wr(16'h0001, 8'hff);
        rd_chk(16'h0001, 8'h00);
    endtask

    task automatic pwm_channel;
        int n;
        logic p;
        wr(per_lo[15:0], 8'h04);
        wr(dut_lo[15:0], 8'h01);
        wr(`IDX_ENABLE, 8'h01);
        for (int k = 0; k < 2; k++) begin
            repeat (10) @(posedge clk_i);
            n = 0;
            repeat (40) begin
                @(posedge clk_i);
                n += pwm_o[0];
            end
            chk(n, k ? 30 : 10);
            wr(`IDX_CTRL0, 8'h40);
        end
        chk({29'h0, pwm_o[5:3]}, 32'h0);
        // Prescale of one doubles the cycle, so rising edges halve
        wr(`IDX_CTRL0, 8'h00);
        wr(`IDX_PSC, 8'h01);
        repeat (10) @(posedge clk_i);
        n = 0;
        p = pwm_o[0];
        repeat (40) begin
            @(posedge clk_i);
            n += (pwm_o[0] && !p);
            p = pwm_o[0];
        end
        chk(n, 5);
        wr(`IDX_PSC, 8'h00);
        rd_chk(`IDX_FLAGS, 8'h01);
        chk(irq_o, 1'b0);
        wr(`IDX_MASK, 8'h01);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wr(`IDX_ENABLE, 8'h00);
        wr(`IDX_FLAGS, 8'h01);
        rd_chk(`IDX_FLAGS, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
    endtask

    task automatic strip_pair(input logic s2, input logic [7:0] ctl, input logic [7:0] b0,
                              input logic [7:0] b1, input logic [15:0] ew, input logic pz);
        logic [15:0] di;
        logic [7:0]  st;
        logic [7:0]  c0;
        int          n;
        di = s2 ? `IDX_DAT1 : `IDX_DAT0;
        c0 = s2 ? cnt2 : cnt1;
        wr(`IDX_CTRL0 + (s2 ? 16'h2 : 16'h1), ctl);
        wr(di, b0);
        wb(1'b0, `IDX_STATUS, 8'h00, st);
        chk(st[s2 ? `BUSY1_BIT : `BUSY0_BIT], 1'b1);
        n = 0;
        do begin
            wb(1'b0, `IDX_STATUS, 8'h00, st);
            n++;
        end while (st[s2 ? `FULL1_BIT : `FULL0_BIT] && n < 100);
        wr(di, b1);
        rd_chk(di, b1);
        n = 0;
        while ((s2 ? cnt2 : cnt1) !== c0 + 8'h02 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chk(s2 ? word2 : word1, ew);
        n = s2 ? gap2 : gap1;
        chk(pz ? (n >= 31 && n <= 46) : (n < 31), 1'b1);
        repeat (80) @(posedge clk_i);
        wb(1'b0, `IDX_STATUS, 8'h00, st);
        chk(st[s2 ? `BUSY1_BIT : `BUSY0_BIT], 1'b0);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_values;
        reg_access;
        pwm_channel;
        for (int c = 1; c < 3; c++) begin
            wr(per_lo[16*c +: 16], 8'h08);
            wr(dut_lo[16*c +: 16], 8'h02);
            // Strip mode before enable keeps plain PWM pulses off the receivers
            wr(`IDX_CTRL0 + 16'(c), 8'h08);
        end
        wr(`IDX_ONE_LO, 8'h05);
        wr(`IDX_PAUSE_LO, 8'h1e);
        wr(`IDX_ENABLE, 8'h06);
        strip_pair(1'b0, 8'h10, 8'ha5, 8'h3c, 16'ha53c, 1'b0);
        strip_pair(1'b0, 8'h0c, 8'h55, 8'hf0, 16'haa0f, 1'b1);
        strip_pair(1'b1, 8'h38, 8'h81, 8'h7e, 16'h817e, 1'b0);
        end_of_test;
    end
endmodule
